// file: verilog/dpll_reference_selector.sv
// Reference input selector with hitless switchover control and Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "refsel_defines.svh"
module dpll_reference_selector
  import refsel_pkg::*;
#(
  parameter int NREF = `RS_NUM_REFS,
  parameter int PW   = `RS_PHASE_W
)
(
  input  wire logic             clk,            // 125 MHz system clock
  input  wire logic             sys_rst,        // Synchronous reset, active high
  input  wire logic [5:0]       wb_adr_i,       // Wishbone byte address
  input  wire logic [31:0]      wb_dat_i,       // Wishbone write data
  input  wire logic [3:0]       wb_sel_i,       // Wishbone byte enables
  input  wire logic             wb_we_i,        // Wishbone write
  input  wire logic             wb_cyc_i,       // Wishbone cycle
  input  wire logic             wb_stb_i,       // Wishbone strobe
  output logic [31:0]           wb_dat_o,       // Wishbone read data
  output logic                  wb_ack_o,       // Wishbone acknowledge
  input  wire logic [15:0]      mon_flags,      // Monitor flags, 4 per input
  input  wire logic [NREF-1:0]  ref_gap,        // Input is inside a gap
  input  wire logic [NREF*PW-1:0] ref_phase,    // Measured phase per input
  input  wire logic [NREF-1:0]  ref_freq_lock,  // Input frequency-locked to current
  input  wire logic [1:0]       sel_pins,       // Manual choice from pins
  input  wire logic             history_valid,  // Tuning word history valid
  input  wire logic             loop_lock,      // Loop lock detector
  input  wire logic             xo_in_range,    // XO frequency detector result
  output logic [1:0]            selected_ref,   // Selected input status pins
  output logic                  xo_frequency_loss_flag, // XO loss status pin
  output loop_state_t           loop_state,     // Loop operating state
  output logic [PW-1:0]         out_phase,      // Phase sent to the loop
  output logic                  loop_soft_reset // One-cycle loop reset pulse
);

  // =====================================================
  // Registers
  sel_mode_t    mode_q;
  logic         pin_select_q;
  logic         hitless_en_q;
  logic         phase_cancel_q;
  logic         phase_slew_enable_q;
  logic         xo_monitor_bypass_q;
  logic [11:0]  prio_q;
  logic [1:0]   manual_reference_choice_q;
  logic [15:0]  valid_time_q;
  logic [15:0]  mon_en_q;
  logic [15:0]  phase_slew_step_limit_q;
  logic [15:0]  phase_slew_step_interval_q;
  logic         wb_req;
  logic         wb_wr;
  logic [31:0]  rd_d;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  // Merges a write into a register under its byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  logic [31:0] ctrl_w;
  logic [31:0] prio_w;
  logic [31:0] vt_w;
  logic [31:0] me_w;
  logic [31:0] sl_w;
  assign ctrl_w = merge({24'h0, 1'b0, xo_monitor_bypass_q, phase_slew_enable_q,
                         phase_cancel_q, hitless_en_q, pin_select_q, mode_q}, wb_dat_i, wb_sel_i);
  assign prio_w = merge({14'h0, manual_reference_choice_q, 4'h0, prio_q}, wb_dat_i, wb_sel_i);
  assign vt_w   = merge({16'h0, valid_time_q}, wb_dat_i, wb_sel_i);
  assign me_w   = merge({16'h0, mon_en_q}, wb_dat_i, wb_sel_i);
  assign sl_w   = merge({phase_slew_step_interval_q, phase_slew_step_limit_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      {phase_cancel_q, hitless_en_q, pin_select_q} <= 3'(`RS_CTRL_RST >> `RS_CTRL_PINSEL);
      mode_q                    <= MODE_AUTO_REVERT;
      phase_slew_enable_q       <= 1'b0;
      xo_monitor_bypass_q       <= 1'b0;
    end
    else if (wb_wr && wb_adr_i == `RS_OFF_CTRL)
    begin
      mode_q              <= sel_mode_t'(ctrl_w[`RS_CTRL_MODE_LSB +: 2]);
      pin_select_q        <= ctrl_w[`RS_CTRL_PINSEL];
      hitless_en_q        <= ctrl_w[`RS_CTRL_HITLESS];
      phase_cancel_q      <= ctrl_w[`RS_CTRL_CANCEL];
      phase_slew_enable_q <= ctrl_w[`RS_CTRL_SLEW];
      xo_monitor_bypass_q <= ctrl_w[`RS_CTRL_XOBYP];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      manual_reference_choice_q   <= 2'(`RS_PRIO_RST >> `RS_PRIO_MAN_LSB);
      prio_q                      <= 12'(`RS_PRIO_RST);
      valid_time_q                <= `RS_VALTIME_RST;
      mon_en_q                    <= `RS_MONEN_RST;
      phase_slew_step_limit_q     <= `RS_SLEW_LIM_RST;
      phase_slew_step_interval_q  <= `RS_SLEW_TMR_RST;
    end
    else if (wb_wr)
    begin
      if (wb_adr_i == `RS_OFF_PRIO)
      begin
        prio_q                    <= prio_w[11:0];
        manual_reference_choice_q <= prio_w[`RS_PRIO_MAN_LSB +: 2];
      end
      if (wb_adr_i == `RS_OFF_VALTIME)
        valid_time_q <= vt_w[15:0];
      if (wb_adr_i == `RS_OFF_MONEN)
        mon_en_q <= me_w[15:0];
      if (wb_adr_i == `RS_OFF_SLEW)
      begin
        phase_slew_step_limit_q    <= sl_w[15:0];
        phase_slew_step_interval_q <= sl_w[`RS_SLEW_TIMER_LSB +: 16];
      end
    end
  end

  // Soft reset is a self-clearing command bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      loop_soft_reset <= 1'b0;
    else
      loop_soft_reset <= wb_wr && wb_adr_i == `RS_OFF_CTRL && wb_sel_i[0] && wb_dat_i[`RS_CTRL_SOFTRST];
  end

  // =====================================================
  // Input validation
  logic [NREF-1:0] ref_valid;

  for (genvar g = 0; g < NREF; g++)
  begin : g_val
    ref_validator #(.TIME_W(16)) u_val
    (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .mon_flags  (mon_flags[g*4 +: 4]),
      .mon_en     (mon_en_q[g*4 +: 4]),
      .valid_time (valid_time_q),
      .valid_q    (ref_valid[g])
    );
  end

  // =====================================================
  // Selection
  // Best valid input: lowest nonzero priority, ties to lowest index
  function automatic logic [2:0] best_ref(input logic [NREF-1:0] vld, input logic [11:0] pr);
    logic [2:0] res;
    logic [2:0] bp;
    res = 3'h0;
    bp  = 3'h0;
    for (int i = NREF - 1; i >= 0; i--)
      if (vld[i] && pr[i*3 +: 3] != 3'h0 && (bp == 3'h0 || pr[i*3 +: 3] <= bp))
      begin
        bp  = pr[i*3 +: 3];
        res = {1'b1, 2'(i)};
      end
    return res;
  endfunction

  logic [2:0]  best;
  logic [1:0]  man_ref;
  logic [1:0]  sel_d;
  logic        cur_ok;
  logic        man_ok;
  logic        xo_ok;
  logic        have_ref;

  assign best    = best_ref(ref_valid, prio_q);
  assign man_ref = pin_select_q ? sel_pins : manual_reference_choice_q;
  assign cur_ok  = ref_valid[selected_ref] && prio_q[selected_ref*3 +: 3] != 3'h0;
  assign man_ok  = ref_valid[man_ref];
  assign xo_ok   = xo_monitor_bypass_q | xo_in_range;

  always_comb
  begin
    sel_d    = selected_ref;
    have_ref = 1'b0;
    unique case (mode_q)
      MODE_AUTO_REVERT:
      begin
        have_ref = best[2];
        if (best[2])
          sel_d = best[1:0];
      end
      MODE_AUTO_NONREVERT:
      begin
        have_ref = cur_ok | best[2];
        if (!cur_ok && best[2])
          sel_d = best[1:0];
      end
      MODE_MAN_FALLBACK:
      begin
        have_ref = man_ok | best[2];
        if (man_ok)
          sel_d = man_ref;
        else if (best[2])
          sel_d = best[1:0];
        else
          sel_d = man_ref;
      end
      MODE_MAN_HOLDOVER:
      begin
        have_ref = man_ok;
        sel_d    = man_ref;
      end
    endcase
  end

  // Registered each cycle from validity, priorities, mode and the current selection
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      selected_ref <= 2'h0;
    else
      selected_ref <= sel_d;
  end

  // =====================================================
  // Loop state
  loop_state_t ls_d;

  always_comb
  begin
    if (!xo_ok || !have_ref)
      ls_d = (xo_ok && history_valid) ? LOOP_HOLDOVER : LOOP_FREE_RUN;
    else if (loop_lock && loop_state != LOOP_FREE_RUN && loop_state != LOOP_HOLDOVER)
      ls_d = LOOP_LOCKED;
    else
      ls_d = LOOP_ACQUIRE;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || loop_soft_reset)
      loop_state <= LOOP_FREE_RUN;
    else
      loop_state <= ls_d;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      xo_frequency_loss_flag <= 1'b0;
    else
      xo_frequency_loss_flag <= ~xo_in_range;
  end

  // =====================================================
  // Phase build-out and slew
  logic signed [PW-1:0] buildout_q;
  logic signed [PW-1:0] tgt_q;
  logic signed [PW-1:0] new_ph;
  logic signed [PW-1:0] old_ph;
  logic [15:0]          tick_cnt_q;
  logic                 tick;
  logic                 switching;
  logic                 entering;
  logic                 slew_active_q;

  assign new_ph    = ref_phase[sel_d*PW +: PW];
  assign old_ph    = ref_phase[selected_ref*PW +: PW];
  assign switching = sel_d != selected_ref && have_ref;
  assign entering  = ls_d == LOOP_ACQUIRE &&
                     (loop_state == LOOP_HOLDOVER || loop_state == LOOP_FREE_RUN);
  assign tick      = tick_cnt_q == 16'h0;

  // Step timer gives one enable every programmed interval plus one cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst || tick)
      tick_cnt_q <= phase_slew_step_interval_q;
    else
      tick_cnt_q <= tick_cnt_q - 16'h1;
  end

  // Moves a value toward a goal by at most lim
  function automatic logic [PW-1:0] step_to(input logic signed [PW-1:0] cur,
                                            input logic signed [PW-1:0] goal,
                                            input logic [15:0] lim);
    logic signed [PW:0] diff;
    diff = {goal[PW-1], goal} - {cur[PW-1], cur};
    if (diff > $signed({1'b0, lim}))
      return cur + PW'(lim);
    if (diff < -$signed({1'b0, lim}))
      return cur - PW'(lim);
    return goal;
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      buildout_q <= '0;
    else if (switching && hitless_en_q && phase_cancel_q && ref_freq_lock[sel_d])
      buildout_q <= buildout_q + (new_ph - old_ph);
    else if (switching && !hitless_en_q)
      buildout_q <= '0;
    else if (phase_slew_enable_q && tick)
      buildout_q <= step_to(buildout_q, '0, phase_slew_step_limit_q);
  end

  // Slew engages on acquisition entry, on unlocked switches and on any switch with phase cancellation set
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      slew_active_q <= 1'b0;
    else if (entering || (switching && !ref_freq_lock[sel_d]) || (switching && phase_cancel_q))
      slew_active_q <= phase_slew_enable_q;
    else if (out_phase == tgt_q || !phase_slew_enable_q)
      slew_active_q <= 1'b0;  // Dropping the enable ends a slew that could never catch a moving target
  end

  // A gap freezes the target so the output stays periodic
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tgt_q <= '0;
    else if (!ref_gap[sel_d])
      tgt_q <= new_ph - buildout_q;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      out_phase <= '0;
    else if (!(slew_active_q || phase_slew_enable_q))
      out_phase <= tgt_q;
    else if (tick)
      out_phase <= step_to(out_phase, tgt_q, phase_slew_step_limit_q);
  end

  // =====================================================
  // Read path
  always_comb
  begin
    rd_d = 32'h0;
    unique case (wb_adr_i)
      `RS_OFF_CTRL:    rd_d = {24'h0, 1'b0, xo_monitor_bypass_q, phase_slew_enable_q, phase_cancel_q,
                               hitless_en_q, pin_select_q, mode_q};
      `RS_OFF_PRIO:    rd_d = {14'h0, manual_reference_choice_q, 4'h0, prio_q};
      `RS_OFF_VALTIME: rd_d = {16'h0, valid_time_q};
      `RS_OFF_MONEN:   rd_d = {16'h0, mon_en_q};
      `RS_OFF_SLEW:    rd_d = {phase_slew_step_interval_q, phase_slew_step_limit_q};
      `RS_OFF_STATUS:  rd_d = {21'h0, loop_lock, history_valid, xo_frequency_loss_flag,
                               ref_valid, loop_state, selected_ref};
      `RS_OFF_PHASE:   rd_d = {16'(buildout_q), 16'(out_phase)};
      default:         rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_d : 32'h0;
    end
  end

endmodule
`default_nettype wire

// file: inc/refsel_defines.svh
// Register offsets, field positions, reset values and counts of the reference selector
`ifndef REFSEL_DEFINES_SVH
`define REFSEL_DEFINES_SVH

`define RS_NUM_REFS        4
`define RS_PRIO_W          3
`define RS_PHASE_W         16

`define RS_OFF_CTRL        6'h00
`define RS_OFF_PRIO        6'h04
`define RS_OFF_VALTIME     6'h08
`define RS_OFF_MONEN       6'h0c
`define RS_OFF_SLEW        6'h10
`define RS_OFF_STATUS      6'h14
`define RS_OFF_PHASE       6'h18

`define RS_CTRL_MODE_LSB   0
`define RS_CTRL_PINSEL     2
`define RS_CTRL_HITLESS    3
`define RS_CTRL_CANCEL     4
`define RS_CTRL_SLEW       5
`define RS_CTRL_XOBYP      6
`define RS_CTRL_SOFTRST    7
`define RS_PRIO_MAN_LSB    16
`define RS_SLEW_TIMER_LSB  16

`define RS_CTRL_RST        8'h18
`define RS_PRIO_RST        18'h008d1
`define RS_VALTIME_RST     16'h0010
`define RS_MONEN_RST       16'h7777
`define RS_SLEW_LIM_RST    16'h0004
`define RS_SLEW_TMR_RST    16'h0008

`endif

// file: inc/refsel_pkg.sv
// Types shared by the reference selector modules
package refsel_pkg;

  typedef enum logic [1:0] {
    MODE_AUTO_REVERT,
    MODE_AUTO_NONREVERT,
    MODE_MAN_FALLBACK,
    MODE_MAN_HOLDOVER
  } sel_mode_t;

  typedef enum logic [1:0] {
    LOOP_FREE_RUN,
    LOOP_HOLDOVER,
    LOOP_ACQUIRE,
    LOOP_LOCKED
  } loop_state_t;

endpackage

// file: verilog/ref_validator.sv
// Validation timer for one reference input
`timescale 1ns/1ps
`default_nettype none
module ref_validator
#(
  parameter int TIME_W = 16
)
(
  input  wire logic              clk,        // System clock
  input  wire logic              sys_rst,    // Synchronous reset
  input  wire logic [3:0]        mon_flags,  // Raw monitor flags
  input  wire logic [3:0]        mon_en,     // Monitor enables
  input  wire logic [TIME_W-1:0] valid_time, // Clear cycles needed, less one
  output logic                   valid_q     // Qualified for selection
);

  logic [TIME_W-1:0] clear_cnt_q;
  logic              flagged;

  // A disabled detector never disqualifies its input
  assign flagged = |(mon_flags & mon_en);

  // =====================================================
  // Clear-time counter
  always_ff @(posedge clk)
  begin
    if (sys_rst || flagged)
    begin
      clear_cnt_q <= '0;
      valid_q     <= 1'b0;
    end
    else if (clear_cnt_q >= valid_time)
    begin
      valid_q <= 1'b1;
    end
    else
    begin
      clear_cnt_q <= clear_cnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: dv/refsel_monitor.sv
// Port checker for the reference selector
`timescale 1ns/1ps
`default_nettype none
module refsel_monitor
  import refsel_pkg::*;
(
  input wire logic        clk,                    // Clock
  input wire logic        sys_rst,                // Reset
  input wire logic [5:0]  wb_adr_i,               // Address
  input wire logic        wb_we_i,                // Write
  input wire logic        wb_cyc_i,               // Cycle
  input wire logic        wb_stb_i,               // Strobe
  input wire logic [31:0] wb_dat_o,               // Read data
  input wire logic        wb_ack_o,               // Ack
  input wire logic        xo_in_range,            // XO detector
  input wire logic        loop_lock,              // Lock detector
  input wire logic [1:0]  selected_ref,           // Selection
  input wire logic        xo_frequency_loss_flag, // XO loss
  input wire loop_state_t loop_state,             // Loop state
  input wire logic        loop_soft_reset         // Soft reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Register bus
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_status_read: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 6'h14
    |-> wb_dat_o[3:0] == {$past(loop_state), $past(selected_ref)})
    else $error("status word differs from pins");
  // ==========================================
  // Loop and XO status
  a_xo_flag_raw: assert property (1'b1 |=> xo_frequency_loss_flag == !$past(xo_in_range))
    else $error("XO loss flag not the raw detector");
  a_soft_reset_pulse: assert property (loop_soft_reset |=> !loop_soft_reset)
    else $error("soft reset wider than one cycle");
  a_soft_reset_cause: assert property (loop_soft_reset |-> wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 6'h00)
    else $error("soft reset without control write");
  a_soft_reset_free: assert property (loop_soft_reset |-> ##[1:2] loop_state == LOOP_FREE_RUN)
    else $error("soft reset left loop running");
  a_lock_via_acquire: assert property (loop_state == LOOP_LOCKED && $past(loop_state) != LOOP_LOCKED
    |-> $past(loop_state) == LOOP_ACQUIRE && $past(loop_lock))
    else $error("lock reached without acquisition");
endmodule
`default_nettype wire

// file: dv/ref_source_model.sv
// Behavioural reference sources, lock detector and XO detector
`timescale 1ns/1ps
`default_nettype none
module ref_source_model
(
  input  wire logic       clk,           // Clock
  input  wire logic [3:0] fault,         // Faulted inputs
  input  wire logic [3:0] gap_cmd,       // Inputs inside a gap
  input  wire logic       hist_cmd,      // History valid
  input  wire logic       lock_cmd,      // Loop locked
  input  wire logic       xo_cmd,        // XO in range
  output logic [15:0]     mon_flags,     // Monitor flags
  output logic [3:0]      ref_gap,       // Gap per input
  output logic [63:0]     ref_phase,     // Phase per input
  output logic [3:0]      ref_freq_lock, // Frequency lock
  output logic            history_valid, // History valid
  output logic            loop_lock,     // Lock detector
  output logic            xo_in_range    // XO detector
);
  logic [1:0] k_q;
  initial
  begin
    k_q = 2'h0;
    mon_flags = 16'h0;
    ref_gap = 4'h0;
    ref_phase = 64'h3000_2000_1000_0000;
    ref_freq_lock = 4'hf;
    history_valid = 1'b0;
    loop_lock = 1'b0;
    xo_in_range = 1'b1;
  end
  // ==========================================
  // Sources
  always @(posedge clk)
  begin
    k_q <= (k_q == 2'h2) ? 2'h0 : k_q + 2'h1;
    for (int n = 0; n < 4; n++)
    begin
      // A fault trips one enabled monitor, moving each cycle, so no single flag bit is trusted
      mon_flags[4*n +: 4] <= fault[n] ? 4'h1 << k_q : 4'h0;
      ref_phase[16*n +: 16] <= ref_phase[16*n +: 16] + 16'h1;
    end
    ref_gap <= gap_cmd;
    history_valid <= hist_cmd;
    loop_lock <= lock_cmd;
    xo_in_range <= xo_cmd;
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the reference selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import refsel_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic [3:0] wb_sel_i = 4'h0, fault = 4'h0, gap = 4'h0, vld = 4'hf, nf, ref_gap, ref_freq_lock;
  logic [1:0] sel_pins = 2'h0, selected_ref, pins = 2'h0, mfield = 2'h0;
  logic wb_ack_o, history_valid, loop_lock, xo_in_range, xo_frequency_loss_flag, loop_soft_reset;
  logic hist = 1'b0, lock = 1'b0, xo = 1'b1, pinsel = 1'b0, byp = 1'b0;
  logic [15:0] mon_flags, out_phase, prev;
  logic signed [15:0] d;
  logic [63:0] ref_phase;
  loop_state_t loop_state;
  int errors = 0, checks = 0, cycles = 0, seed = 32'he4f94b28, mode = 0, cur = 0;
  int prio[4] = '{1, 2, 3, 4};
  logic [5:0] radr[5] = '{6'h00, 6'h08, 6'h0c, 6'h10, 6'h1c};
  logic [31:0] rexp[5] = '{32'h18, 32'h10, 32'h7777, 32'h0008_0004, 32'h0};
  always #4 clk = ~clk;
  dpll_reference_selector dut (.clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .mon_flags, .ref_gap, .ref_phase, .ref_freq_lock, .sel_pins,
    .history_valid, .loop_lock, .xo_in_range, .selected_ref, .xo_frequency_loss_flag, .loop_state,
    .out_phase, .loop_soft_reset);
  ref_source_model src (.clk, .fault, .gap_cmd(gap), .hist_cmd(hist), .lock_cmd(lock), .xo_cmd(xo), .mon_flags,
    .ref_gap, .ref_phase, .ref_freq_lock, .history_valid, .loop_lock, .xo_in_range);
  // ==========================================
  // Checking and bus tasks
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 64);
    q = wb_dat_o;
    chk_reg("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask
  // Reference model of selection, run after every single change so its memory matches the design
  task automatic eval();
    int b, s, mc;
    bit h;
    logic [1:0] es;
    b = -1;
    mc = pinsel ? pins : mfield;
    for (int n = 3; n >= 0; n--)
      if (vld[n] && prio[n] != 0 && (b < 0 || prio[n] <= prio[b]))
        b = n;
    case (mode)
      0: s = b;
      1: s = (vld[cur] && prio[cur] != 0) ? cur : b;
      2: s = vld[mc] ? mc : (b >= 0) ? b : mc;
      default: s = mc;
    endcase
    // A usable input exists only if the mode may take one; a valid input of priority 0 counts only as the manual choice in modes 2 and 3
    h = (mode == 3) ? vld[mc] : (mode == 2 && vld[mc]) || (mode == 1 && vld[cur] && prio[cur] != 0) || b >= 0;
    if (s >= 0)
      cur = s;
    es = !(xo || byp) ? LOOP_FREE_RUN : h ? LOOP_ACQUIRE : hist ? LOOP_HOLDOVER : LOOP_FREE_RUN;
    repeat (12) @(posedge clk);
    chk_pin("selected_ref", 2'(cur), selected_ref);
    chk_pin("loop_state", es, loop_state);
    wb(6'h14, 1'b0, 32'h0, r);
    chk_reg("status", {21'h0, lock, hist, ~xo, vld, es, 2'(cur)}, r);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wb(6'h1c, 1'b1, 32'hffff_ffff, r);
    for (int i = 0; i < 5; i++)
    begin
      wb(radr[i], 1'b0, 32'h0, r);
      chk_reg("reset word", rexp[i], r);
    end
    $display("test register reset done");
    wb(6'h08, 1'b1, 32'h4, r);
    wb(6'h0c, 1'b1, 32'h7777, r);
    wb(6'h04, 1'b1, 32'h8d1, r);
    eval();
    for (int it = 0; it < 40; it++)
    begin
      pins = 2'($random(seed));
      sel_pins <= pins;
      eval();
      mode = $unsigned($random(seed)) % 4;
      pinsel = 1'($random(seed));
      byp = 1'($random(seed));
      hist <= 1'($random(seed));
      xo <= 1'($random(seed));
      wb(6'h00, 1'b1, {25'h0, byp, 3'h3, pinsel, 2'(mode)}, r);
      eval();
      mfield = 2'($random(seed));
      for (int n = 0; n < 4; n++)
        prio[n] = $unsigned($random(seed)) % 8;
      wb(6'h04, 1'b1, {14'h0, mfield, 4'h0, 3'(prio[3]), 3'(prio[2]), 3'(prio[1]), 3'(prio[0])}, r);
      eval();
      nf = 4'($random(seed));
      fault <= fault | nf;
      vld = ~(fault | nf);
      eval();
      fault <= nf;
      vld = ~nf;
      eval();
    end
    $display("test random selection done");
    fault <= 4'h0;
    xo <= 1'b1;
    lock <= 1'b1;
    wb(6'h00, 1'b1, 32'h38, r);
    wb(6'h04, 1'b1, 32'h8d1, r);
    repeat (20) @(posedge clk);
    chk_pin("loop_state", LOOP_LOCKED, loop_state);
    wb(6'h00, 1'b1, 32'hb8, r);
    repeat (20) @(posedge clk);
    chk_pin("loop_state", LOOP_LOCKED, loop_state);
    fault <= 4'h1;
    prev = out_phase;
    repeat (40)
    begin
      @(posedge clk);
      d = out_phase - prev;
      chk_reg("phase step", 32'h0, 32'(d > 16'sh4 || d < -16'sh4));
      prev = out_phase;
    end
    chk_pin("selected_ref", 2'h1, selected_ref);
    $display("test lock and slew done");
    wb(6'h00, 1'b1, 32'h18, r);
    gap <= 4'hf;
    repeat (4) @(posedge clk);
    prev = out_phase;
    repeat (8) @(posedge clk);
    chk_reg("gap phase", {16'h0, prev}, {16'h0, out_phase});
    gap <= 4'h0;
    repeat (4) @(posedge clk);
    chk_reg("gap release", 32'h0, 32'(out_phase == prev));
    $display("test gapped input done");
    summarize();
  end
endmodule
bind dpll_reference_selector refsel_monitor mon (.clk, .sys_rst, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .xo_in_range, .loop_lock, .selected_ref, .xo_frequency_loss_flag, .loop_state,
  .loop_soft_reset);
`default_nettype wire
